/* design/cam_timing_regs.vh */
`ifndef CAM_TIMING_REGS_VH
`define CAM_TIMING_REGS_VH
// ----------------------------------------
// cycle geometry
// ----------------------------------------
`define DEG_LAST 9'h167
`define DIGIT_COUNT 12
`define DIGIT_PITCH 9'h012
`define DIGIT_MAKE 9'h009
`define DIGIT_BREAK 9'h012
`define CORR_COUNT 5
`define CORR_PITCH 9'h024
`define CORR_MAKE9 9'h006
`define CORR_BREAK9 9'h014
`define TOTAL_COUNT 10
`define TOTAL_MAKE 9'h009
`define TOTAL_BREAK 9'h012
`define CARRY_MAKE 9'h0e1
`define CARRY_BREAK 9'h0e2
// ----------------------------------------
// make / break angles of the single cams
// ----------------------------------------
`define RST_M 9'h15d
`define RST_B 9'h003
`define SUB_M 9'h007
`define SUB_B 9'h015
`define SPD_M 9'h02d
`define SPD_B 9'h012
`define CLA_M 9'h115
`define CLA_B 9'h123
`define CLB_M 9'h11a
`define CLB_B 9'h128
`define PICK_M 9'h125
`define PICK_B 9'h157
`define PRE_M 9'h150
`define PRE_B 9'h128
`define SKIP_M 9'h0ff
`define SKIP_B 9'h113
`define CAR_M 9'h109
`define CAR_B 9'h11d
`define ILK_M 9'h0f9
`define ILK_B 9'h11d
`define CYA_M 9'h0eb
`define CYA_B 9'h113
`define CYB_M 9'h131
`define CYB_B 9'h0b9
`define SEL_M 9'h0fc
`define SEL_B 9'h0e1
`define ZA_M 9'h000
`define ZA_B 9'h0a3
`define ZB_M 9'h0b3
`define ZB_B 9'h0da
`define UNEQ_M 9'h012
`define UNEQ_B 9'h01e
`define UNEQ9_B 9'h01b
`define CMPA_M 9'h000
`define CMPA_B 9'h0ac
`define CMPB_M 9'h0bf
`define CMPB_B 9'h0e2
`define SETUP_M 9'h0e1
`define SETUP_B 9'h0f5
`define POST_M 9'h10e
`define POST_B 9'h11c
`define PIL_M 9'h032
`define PIL_B 9'h040
`define NEG_M 9'h0eb
`define NEG_B 9'h10f
`define CPK_M 9'h0c6
`define CPK_B 9'h0ee
`endif

/* design/cycle_cam_timing_generator.v */
// How it works
// - twelve digit impulses 9..0,11,12; 9 at 9-18, each later 18 degrees on
// - correction digits 1,3,5,7,9 at 150,114,78,42,6 for 14 degrees
// - total print impulses 9..0 every 18 degrees plus carry impulse at 225
// - reset-cycle counter start from 349 wrapping to 3
// - subtract counter start from 7 to 21
// - speed hold from 45 through 359 wrapping to 18
// - clutch energize is 277-291 AND 282-296, giving 282-291
// - clutch magnet pick from 293 to 343
// - feed clutch pre-energize from 336 wrapping to 296
// - all-skips pick from 255 to 275
// - carriage skip start from 265 to 285
// - interlock release pick from 249 to 285
// - cycles pick at 235-275 and 305 wrapping to 185
// - selector hold 252 wrapping to 225, break never late
// - zero control 0-163 and 179-218, zero position excluded
// - unequal test 18-30, digit 9 test 18-27
// - compare hold two windows, second 191-226
// - program setup from 225 to 245
// - post-test program start from 270 to 284
// - negative balance test start from 235 to 271
// - carry relay pick from 198 to 238
// - program interlock pick from 50 to 64
`timescale 1ns/1ps
`include "cam_timing_regs.vh"
`default_nettype none
module cycle_cam_timing_generator (
	// clock and reset
	input wire clk,
	input wire nrst,
	input wire ce,
	// cycle position
	output reg [8:0] degree_r,
	// impulse groups
	output reg [11:0] digit_impulse_cam,
	output reg [4:0] correction_digit_cam,
	output reg [9:0] total_print_cam,
	output reg total_carry_cam,
	// single cams
	output reg reset_cycle_start_cam,
	output reg subtract_start_cam,
	output reg speed_hold_cam,
	output reg clutch_ctrl_cam,
	output reg clutch_magnet_pick_cam,
	output reg feed_clutch_preenergize_cam,
	output reg skip_all_pick_cam,
	output reg carriage_skip_start_cam,
	output reg interlock_release_cam,
	output reg cycles_pick_cam,
	output reg selector_hold_cam,
	output reg zero_control_cam,
	output reg unequal_test_cam,
	output reg unequal_test9_cam,
	output reg compare_hold_cam,
	output reg program_setup_cam,
	output reg post_test_program_cam,
	output reg program_interlock_cam,
	output reg neg_balance_test_cam,
	output reg carry_pick_cam
);

// ----------------------------------------
// window test
// ----------------------------------------
// make inclusive, break exclusive; break below make wraps through zero
function win;
	input [8:0] p;
	input [8:0] mk;
	input [8:0] bk;
	begin
		if (mk <= bk)
			win = (p >= mk) && (p < bk);
		else
			win = (p >= mk) || (p < bk);
	end
endfunction

// ----------------------------------------
// degree counter
// ----------------------------------------
// outputs are registered, so they are decoded from the next position
// and line up exactly with degree_r
wire [8:0] deg_nxt;
assign deg_nxt = (degree_r == `DEG_LAST) ? 9'h000 : degree_r + 9'h001;

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		degree_r <= 9'h000;
	else if (ce)
		degree_r <= deg_nxt;
end

// ----------------------------------------
// impulse groups
// ----------------------------------------
genvar i;
generate
	// index arithmetic is 32 bits wide; every angle fits in the low 9
	for (i = 0; i < `DIGIT_COUNT; i = i + 1) begin : g_dig
		wire [31:0] mk_w;
		wire [31:0] bk_w;
		assign mk_w = `DIGIT_MAKE + i * `DIGIT_PITCH;
		assign bk_w = `DIGIT_BREAK + i * `DIGIT_PITCH;
		// bit 0 is the 9 impulse, bit 11 the 12 impulse
		always @(posedge clk or negedge nrst) begin
			if (!nrst)
				digit_impulse_cam[i] <= 1'b0;
			else if (ce)
				digit_impulse_cam[i] <= win(deg_nxt, mk_w[8:0],
					bk_w[8:0]);
		end
	end
	for (i = 0; i < `CORR_COUNT; i = i + 1) begin : g_cor
		wire [31:0] mk_w;
		wire [31:0] bk_w;
		assign mk_w = `CORR_MAKE9 + i * `CORR_PITCH;
		assign bk_w = `CORR_BREAK9 + i * `CORR_PITCH;
		// bit 0 is digit 9 at 6, bit 4 digit 1 at 150
		always @(posedge clk or negedge nrst) begin
			if (!nrst)
				correction_digit_cam[i] <= 1'b0;
			else if (ce)
				correction_digit_cam[i] <= win(deg_nxt, mk_w[8:0],
					bk_w[8:0]);
		end
	end
	for (i = 0; i < `TOTAL_COUNT; i = i + 1) begin : g_tot
		wire [31:0] mk_w;
		wire [31:0] bk_w;
		assign mk_w = `TOTAL_MAKE + i * `DIGIT_PITCH;
		assign bk_w = `TOTAL_BREAK + i * `DIGIT_PITCH;
		always @(posedge clk or negedge nrst) begin
			if (!nrst)
				total_print_cam[i] <= 1'b0;
			else if (ce)
				total_print_cam[i] <= win(deg_nxt, mk_w[8:0],
					bk_w[8:0]);
		end
	end
endgenerate

// ----------------------------------------
// single cams
// ----------------------------------------
// each cam resets to its own level at degree 0, so a contact whose
// window spans zero already reads closed while the counter is held
always @(posedge clk or negedge nrst) begin
	if (!nrst)
		total_carry_cam <= 1'b0;
	else if (ce)
		total_carry_cam <= win(deg_nxt, `CARRY_MAKE, `CARRY_BREAK);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		reset_cycle_start_cam <= 1'b1;
	else if (ce)
		reset_cycle_start_cam <= win(deg_nxt, `RST_M, `RST_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		subtract_start_cam <= 1'b0;
	else if (ce)
		subtract_start_cam <= win(deg_nxt, `SUB_M, `SUB_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		speed_hold_cam <= 1'b1;
	else if (ce)
		speed_hold_cam <= win(deg_nxt, `SPD_M, `SPD_B);
end

// two overlapping contacts in series fix both edges of the pulse
always @(posedge clk or negedge nrst) begin
	if (!nrst)
		clutch_ctrl_cam <= 1'b0;
	else if (ce)
		clutch_ctrl_cam <= win(deg_nxt, `CLA_M, `CLA_B) &
			win(deg_nxt, `CLB_M, `CLB_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		clutch_magnet_pick_cam <= 1'b0;
	else if (ce)
		clutch_magnet_pick_cam <= win(deg_nxt, `PICK_M, `PICK_B);
end

// overlaps the pick window, so the magnet is held once it has pulled in
always @(posedge clk or negedge nrst) begin
	if (!nrst)
		feed_clutch_preenergize_cam <= 1'b1;
	else if (ce)
		feed_clutch_preenergize_cam <= win(deg_nxt, `PRE_M, `PRE_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		skip_all_pick_cam <= 1'b0;
	else if (ce)
		skip_all_pick_cam <= win(deg_nxt, `SKIP_M, `SKIP_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		carriage_skip_start_cam <= 1'b0;
	else if (ce)
		carriage_skip_start_cam <= win(deg_nxt, `CAR_M, `CAR_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		interlock_release_cam <= 1'b0;
	else if (ce)
		interlock_release_cam <= win(deg_nxt, `ILK_M, `ILK_B);
end

// early and late windows share one output
always @(posedge clk or negedge nrst) begin
	if (!nrst)
		cycles_pick_cam <= 1'b1;
	else if (ce)
		cycles_pick_cam <= win(deg_nxt, `CYA_M, `CYA_B) |
			win(deg_nxt, `CYB_M, `CYB_B);
end

// exact break: the degree step itself is the only tolerance
always @(posedge clk or negedge nrst) begin
	if (!nrst)
		selector_hold_cam <= 1'b1;
	else if (ce)
		selector_hold_cam <= win(deg_nxt, `SEL_M, `SEL_B);
end

// the gap at the zero position lets the compare hold coils drop out
always @(posedge clk or negedge nrst) begin
	if (!nrst)
		zero_control_cam <= 1'b1;
	else if (ce)
		zero_control_cam <= win(deg_nxt, `ZA_M, `ZA_B) |
			win(deg_nxt, `ZB_M, `ZB_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		unequal_test_cam <= 1'b0;
	else if (ce)
		unequal_test_cam <= win(deg_nxt, `UNEQ_M, `UNEQ_B);
end

// the 9 test ends early to leave margin for brush skew
always @(posedge clk or negedge nrst) begin
	if (!nrst)
		unequal_test9_cam <= 1'b0;
	else if (ce)
		unequal_test9_cam <= win(deg_nxt, `UNEQ_M, `UNEQ9_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		compare_hold_cam <= 1'b1;
	else if (ce)
		compare_hold_cam <= win(deg_nxt, `CMPA_M, `CMPA_B) |
			win(deg_nxt, `CMPB_M, `CMPB_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		program_setup_cam <= 1'b0;
	else if (ce)
		program_setup_cam <= win(deg_nxt, `SETUP_M, `SETUP_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		post_test_program_cam <= 1'b0;
	else if (ce)
		post_test_program_cam <= win(deg_nxt, `POST_M, `POST_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		program_interlock_cam <= 1'b0;
	else if (ce)
		program_interlock_cam <= win(deg_nxt, `PIL_M, `PIL_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		neg_balance_test_cam <= 1'b0;
	else if (ce)
		neg_balance_test_cam <= win(deg_nxt, `NEG_M, `NEG_B);
end

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		carry_pick_cam <= 1'b0;
	else if (ce)
		carry_pick_cam <= win(deg_nxt, `CPK_M, `CPK_B);
end

endmodule
`default_nettype wire

/* verif/cam_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cam_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// watched outputs
	input wire logic [8:0] degree_r,
	input wire logic [11:0] digit_impulse_cam,
	input wire logic reset_cycle_start_cam,
	input wire logic speed_hold_cam,
	input wire logic clutch_ctrl_cam,
	input wire logic clutch_magnet_pick_cam,
	input wire logic selector_hold_cam,
	input wire logic zero_control_cam
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_deg_wrap: assert property (
		ce && degree_r == 9'h167 |=> degree_r == 9'h000)
		else $error("no wrap");
	a_digit_nine: assert property (
		digit_impulse_cam[0] == (degree_r >= 9'h009 && degree_r < 9'h012))
		else $error("digit 9");
	a_start_wrap: assert property (
		degree_r inside {9'h002, 9'h003}
		|-> reset_cycle_start_cam == (degree_r == 9'h002))
		else $error("start wrap");
	a_speed_hold: assert property (
		speed_hold_cam == !(degree_r >= 9'h012 && degree_r < 9'h02d))
		else $error("speed hold");
	a_clutch_rise: assert property ($rose(clutch_ctrl_cam) |-> degree_r == 9'h11a)
		else $error("clutch");
	a_pick_rise: assert property ($rose(clutch_magnet_pick_cam) |-> degree_r == 9'h125)
		else $error("pick");
	a_sel_break: assert property ($fell(selector_hold_cam) |-> degree_r == 9'h0e1)
		else $error("selector");
	a_zero_gap: assert property (
		zero_control_cam |-> !(degree_r inside {[9'h0a3:9'h0b2]}))
		else $error("zero gap");
	c_wrap: cover property (ce && degree_r == 9'h167);
	c_freeze: cover property (!ce);
	c_clutch: cover property ($rose(clutch_ctrl_cam));
endmodule
bind cycle_cam_timing_generator cam_monitor cam_monitor_inst (.clk, .nrst,
	.ce, .degree_r, .digit_impulse_cam, .reset_cycle_start_cam,
	.speed_hold_cam, .clutch_ctrl_cam, .clutch_magnet_pick_cam,
	.selector_hold_cam, .zero_control_cam);
`default_nettype wire

/* verif/relay_model.sv */
`timescale 1ns/1ps
`default_nettype none
module relay_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// timed impulses
	input wire logic [11:0] digit_impulse_cam,
	// relay pick tally
	output logic [7:0] pick_count_r
);
	logic [11:0] last_r;
	// a relay picks once on each leading edge, however long the impulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			last_r <= 12'h000;
			pick_count_r <= 8'h00;
		end else begin
			last_r <= digit_impulse_cam;
			pick_count_r <= pick_count_r
				+ 8'($countones(digit_impulse_cam & ~last_r));
		end
	end
endmodule
`default_nettype wire

/* verif/cycle_cam_timing_generator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
	begin \
		checks++; \
		if ((a) !== (b)) begin \
			err_count++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
		end \
	end
module cycle_cam_timing_generator_tb;
	logic clk, nrst, ce, total_carry_cam, reset_cycle_start_cam;
	logic subtract_start_cam, speed_hold_cam, clutch_ctrl_cam;
	logic clutch_magnet_pick_cam, feed_clutch_preenergize_cam;
	logic skip_all_pick_cam, carriage_skip_start_cam;
	logic interlock_release_cam, cycles_pick_cam, selector_hold_cam;
	logic zero_control_cam, unequal_test_cam, unequal_test9_cam;
	logic compare_hold_cam, program_setup_cam, post_test_program_cam;
	logic program_interlock_cam, neg_balance_test_cam, carry_pick_cam;
	logic [8:0] degree_r;
	logic [11:0] digit_impulse_cam;
	logic [4:0] correction_digit_cam;
	logic [9:0] total_print_cam;
	logic [7:0] pick_count_r;
	logic [20:0] act, ex;
	int err_count, checks, cyc;
	// ---
	// window table: make, break, second make, second break
	// ---
	int rows [21][4] = '{'{349,3,0,0}, '{7,21,0,0}, '{45,18,0,0},
		'{282,291,0,0}, '{293,343,0,0}, '{336,296,0,0},
		'{255,275,0,0}, '{265,285,0,0}, '{249,285,0,0},
		'{235,275,305,185}, '{252,225,0,0}, '{0,163,179,218},
		'{18,30,0,0}, '{18,27,0,0}, '{0,172,191,226},
		'{225,245,0,0}, '{270,284,0,0}, '{50,64,0,0},
		'{235,271,0,0}, '{198,238,0,0}, '{225,226,0,0}};
	assign act = {total_carry_cam, carry_pick_cam, neg_balance_test_cam,
		program_interlock_cam, post_test_program_cam, program_setup_cam,
		compare_hold_cam, unequal_test9_cam, unequal_test_cam,
		zero_control_cam, selector_hold_cam, cycles_pick_cam,
		interlock_release_cam, carriage_skip_start_cam, skip_all_pick_cam,
		feed_clutch_preenergize_cam, clutch_magnet_pick_cam, clutch_ctrl_cam,
		speed_hold_cam, subtract_start_cam, reset_cycle_start_cam};
	cycle_cam_timing_generator cycle_cam_timing_generator_inst (.clk,
		.nrst, .ce, .degree_r, .digit_impulse_cam, .correction_digit_cam,
		.total_print_cam, .total_carry_cam, .reset_cycle_start_cam,
		.subtract_start_cam, .speed_hold_cam, .clutch_ctrl_cam,
		.clutch_magnet_pick_cam, .feed_clutch_preenergize_cam,
		.skip_all_pick_cam, .carriage_skip_start_cam, .interlock_release_cam,
		.cycles_pick_cam, .selector_hold_cam, .zero_control_cam,
		.unequal_test_cam, .unequal_test9_cam, .compare_hold_cam,
		.program_setup_cam, .post_test_program_cam, .program_interlock_cam,
		.neg_balance_test_cam, .carry_pick_cam);
	relay_model relay_model_inst (.clk, .nrst, .digit_impulse_cam, .pick_count_r);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic win(int p, int m, int b);
		return (m <= b) ? (p >= m && p < b) : (p >= m || p < b);
	endfunction
	task automatic check_deg(int p);
		logic [11:0] dg;
		logic [4:0] cr;
		logic [9:0] tp;
		for (int i = 0; i < 21; i++)
			ex[i] = win(p, rows[i][0], rows[i][1])
				| win(p, rows[i][2], rows[i][3]);
		for (int i = 0; i < 12; i++) dg[i] = win(p, 9 + 18 * i, 18 + 18 * i);
		for (int i = 0; i < 5; i++) cr[i] = win(p, 6 + 36 * i, 20 + 36 * i);
		for (int i = 0; i < 10; i++) tp[i] = win(p, 9 + 18 * i, 18 + 18 * i);
		`CHK(degree_r, 9'(p))
		`CHK(act, ex)
		`CHK(digit_impulse_cam, dg)
		`CHK(correction_digit_cam, cr)
		`CHK(total_print_cam, tp)
	endtask
	task automatic sweep(int cnt);
		for (int n = 1; n <= cnt; n++) begin
			@(negedge clk);
			check_deg(n % 360);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// the whole run is under 900 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			err_count++;
			give_verdict;
		end
	end
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		`CHK(degree_r, 9'h000)
		check_deg(0);
		sweep(720);
		`CHK(pick_count_r, 8'h18)
		ce = 1'b0;
		repeat (5) @(negedge clk);
		check_deg(0);
		ce = 1'b1;
		repeat (100) @(negedge clk);
		check_deg(100);
		nrst = 1'b0;
		#1;
		`CHK(degree_r, 9'h000)
		check_deg(0);
		@(negedge clk);
		nrst = 1'b1;
		sweep(40);
		give_verdict;
	end
endmodule
`default_nettype wire
